// file: adcss_ana_model.sv
// analog front end model: four inputs, mux, comparator
// assumes the channel select stays put through a conversion
`timescale 1ns/1ns
module adcss_ana_model #(
   parameter logic [31:0] VALS = 32'h7e10c235
) (
   input  wire logic                     clk_in,
   input  wire adcss_pkg::adcss_ana_type ana_in,
   output logic                          cmp_out
);
   // input sits half a step above its code, so an equal code compares high
   assign cmp_out = VALS[ana_in.chan*8 +: 8] >= ana_in.dac_code;
endmodule // adcss_ana_model

// file: adcss_clkdiv.sv
// a/d clock divider: one-cycle enable every div_in core clocks
// assumes synchronous reset copy from the top module
`timescale 1ns/1ns
module adcss_clkdiv (
   input  wire logic       clk_in,
   input  wire logic       rst_b_in,
   input  wire logic [7:0] div_in,
   output logic            tick_out
);
   logic [7:0] cnt_ff;
   logic [7:0] nxt_cnt;
   logic       tick_ff;
   logic       nxt_tick;

   // count down, pulse at zero
   always_comb begin
      nxt_tick = 1'b0;
      nxt_cnt  = cnt_ff - 8'h01;
      if (cnt_ff == 8'h00) begin
         nxt_tick = 1'b1;
         nxt_cnt  = (div_in == 8'h00) ? 8'h00 : div_in - 8'h01;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cnt_ff  <= 8'h00;
         tick_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         tick_ff <= nxt_tick;
      end
   end

   assign tick_out = tick_ff;
endmodule // adcss_clkdiv

// file: adcss_pkg.sv
// package for the a/d scan sequencer: register offsets, fields, modes, timing
// assumes a plain register port with one-cycle read latency
package adcss_pkg;

   // register offsets (word index on the plain register port)
   localparam logic [3:0] ADDR_CTRL    = 4'h0;
   localparam logic [3:0] ADDR_CHSEL   = 4'h1;
   localparam logic [3:0] ADDR_LIMHI   = 4'h2;
   localparam logic [3:0] ADDR_LIMLO   = 4'h3;
   localparam logic [3:0] ADDR_STATUS  = 4'h4;
   localparam logic [3:0] ADDR_RES0    = 4'h5;
   localparam logic [3:0] ADDR_CLKDIV  = 4'h9;

   // ctrl fields
   localparam int CTRL_MODE_LSB = 0;   // [2:0] operating mode
   localparam int CTRL_TRIG_LSB = 3;   // [4:3] start source
   localparam int CTRL_CIE_BIT  = 5;   // completion interrupt enable
   localparam int CTRL_BIE_BIT  = 6;   // boundary interrupt enable
   localparam int CTRL_STOP_BIT = 7;   // write 1 stops conversions

   // status fields (write 1 to clear the flags)
   localparam int STAT_DONE_BIT = 0;
   localparam int STAT_BND_BIT  = 1;
   localparam int STAT_BUSY_BIT = 2;
   localparam int STAT_RUN_BIT  = 3;

   // reset values
   localparam logic [7:0] CTRL_RST   = 8'h00;
   localparam logic [7:0] CHSEL_RST  = 8'h01;
   localparam logic [7:0] LIMHI_RST  = 8'hff;
   localparam logic [7:0] LIMLO_RST  = 8'h00;
   localparam logic [7:0] CLKDIV_RST = 8'h4b;

   // sizes
   localparam int RES_BITS = 8;
   localparam int NUM_CH   = 4;

   // timing: a/d clock near 3.3 mhz from 250 mhz core clock
   localparam int CLK_MHZ      = 250;
   localparam int ADCLK_KHZ    = 3300;
   localparam int ADCLK_DIV    = (CLK_MHZ * 1000) / ADCLK_KHZ;

   typedef enum logic [2:0] {
      ADCSS_FIX_SINGLE  = 3'h0,
      ADCSS_FIX_CONT    = 3'h1,
      ADCSS_SCAN_SINGLE = 3'h2,
      ADCSS_SCAN_CONT   = 3'h3,
      ADCSS_DUAL_CONT   = 3'h4,
      ADCSS_STEP        = 3'h5
   } adcss_mode_type;

   typedef enum logic [1:0] {
      ADCSS_TRIG_NONE  = 2'h0,
      ADCSS_TRIG_TIMER = 2'h1,
      ADCSS_TRIG_IMM   = 2'h2,
      ADCSS_TRIG_EDGE  = 2'h3
   } adcss_trig_type;

   // analog side: channel select, sample, dac code out; comparator in
   typedef struct packed {
      logic [1:0] chan;
      logic       sample;
      logic [7:0] dac_code;
   } adcss_ana_type;

   // result of one conversion handed to the sequencer
   typedef struct packed {
      logic       done;
      logic       early;
      logic [7:0] value;
   } adcss_conv_type;

endpackage

// file: adcss_sar.sv
// successive approximation engine, one bit per a/d clock tick
// assumes comparator input valid by the tick after the dac code changes
`timescale 1ns/1ns
module adcss_sar (
   input  wire logic                     clk_in,
   input  wire logic                     rst_b_in,
   input  wire logic                     tick_in,
   input  wire logic                     start_in,
   input  wire logic                     cmp_in,
   output logic [7:0]                    dac_out,
   output logic                          busy_out,
   output adcss_pkg::adcss_conv_type     conv_out
);
   logic [7:0] val_ff;
   logic [7:0] nxt_val;
   logic [7:0] bit_ff;
   logic [7:0] nxt_bit;
   logic       busy_ff;
   logic       nxt_busy;
   adcss_pkg::adcss_conv_type conv_ff;
   adcss_pkg::adcss_conv_type nxt_conv;
   logic       settle_ff;
   logic       nxt_settle;

   // trial bit set, keep if comparator says input above dac
   // the trial code reaches the comparator a cycle late, so a tick right after a change is skipped
   // a start always restarts, so a run left going after a stop cannot swallow it
   always_comb begin
      nxt_val    = val_ff;
      nxt_bit    = bit_ff;
      nxt_busy   = busy_ff;
      nxt_conv   = '0;
      nxt_settle = 1'b0;
      if (start_in) begin
         nxt_busy   = 1'b1;
         nxt_bit    = 8'h80;
         nxt_val    = 8'h00;
         nxt_settle = 1'b1;
      end else if (busy_ff && tick_in && !settle_ff) begin
         nxt_settle = 1'b1;
         if (cmp_in)
            nxt_val = val_ff | bit_ff;
         nxt_bit = bit_ff >> 1;
         if (bit_ff == 8'h10) begin
            nxt_conv.early = 1'b1;           // upper four bits resolved
            nxt_conv.value = cmp_in ? (val_ff | bit_ff) : val_ff;
         end
         if (bit_ff == 8'h01) begin
            nxt_busy       = 1'b0;
            nxt_conv.done  = 1'b1;
            nxt_conv.value = cmp_in ? (val_ff | bit_ff) : val_ff;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         val_ff  <= 8'h00;
         bit_ff  <= 8'h00;
         busy_ff <= 1'b0;
         conv_ff <= '0;
         settle_ff <= 1'b0;
      end else begin
         val_ff  <= nxt_val;
         bit_ff  <= nxt_bit;
         busy_ff <= nxt_busy;
         conv_ff <= nxt_conv;
         settle_ff <= nxt_settle;
      end
   end

   assign dac_out  = val_ff | bit_ff;
   assign busy_out = busy_ff;
   assign conv_out = conv_ff;
endmodule // adcss_sar

// file: adcss_top.sv
// top of the a/d scan sequencer: register port, triggers, channel sequencing
// assumes synchronous inputs and a comparator that settles within one a/d tick
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ns
module adcss_top (
   input  wire logic                  clk_in,
   input  wire logic                  rst_b_in,
   input  wire logic [3:0]            addr_in,
   input  wire logic [7:0]            wdata_in,
   input  wire logic                  wr_in,
   input  wire logic                  rd_in,
   output logic [7:0]                 rdata_out,
   input  wire logic                  timer_ovf_in,
   input  wire logic                  edge_trigger_pin_in,
   input  wire logic                  cmp_in,
   output adcss_pkg::adcss_ana_type   ana_out,
   output logic                       done_irq_out,
   output logic                       bnd_irq_out
);
   typedef enum logic [1:0] {IDLE_S, CONV_S, WAIT_S} adcss_state_type;

   logic       rst_m_ff;
   logic       rst_s_ff;
   logic       tick;
   logic       sar_busy;
   logic [7:0] dac_code;
   adcss_pkg::adcss_conv_type conv;

   logic [7:0] ctrl_ff, nxt_ctrl;
   logic [3:0] chsel_ff, nxt_chsel;
   logic [7:0] limhi_ff, nxt_limhi;
   logic [7:0] limlo_ff, nxt_limlo;
   logic [7:0] clkdiv_ff, nxt_clkdiv;
   logic [7:0] res_ff [adcss_pkg::NUM_CH];
   logic [7:0] nxt_res [adcss_pkg::NUM_CH];
   logic       done_ff, nxt_done;
   logic       bnd_ff, nxt_bnd;
   logic       early_in_ff, nxt_early_in;
   logic [7:0] rdata_ff, nxt_rdata;
   logic       pin_ff, nxt_pin;
   adcss_state_type state_ff, nxt_state;
   logic [1:0] ch_ff, nxt_ch;
   logic [1:0] slot_ff, nxt_slot;
   logic       run_ff, nxt_run;
   logic       start_ff, nxt_start;
   adcss_pkg::adcss_ana_type ana_ff, nxt_ana;

   adcss_pkg::adcss_mode_type mode;
   adcss_pkg::adcss_trig_type trig;
   logic       trig_evt;
   logic       imm_wr;
   logic [1:0] first_ch;

   // first set channel at or after a given index, wrap flag when passing 3
   function automatic logic [2:0] find_ch(input logic [3:0] sel, input logic [1:0] from);
      logic [2:0] r;
      logic [1:0] c;
      r = {1'b1, from};
      for (int i = 3; i >= 0; i--) begin
         c = 2'(from + 2'(i));
         if (sel[c])
            r = {(c < from) ? 1'b1 : 1'b0, c};
      end
      return r;
   endfunction

   // value outside the limits on the given mask
   function automatic logic outside(input logic [7:0] v, input logic [7:0] hi,
                                    input logic [7:0] lo, input logic [7:0] m);
      return ((v & m) > (hi & m)) || ((v & m) < (lo & m));
   endfunction

   // reset release through two flops
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rst_m_ff <= 1'b0;
         rst_s_ff <= 1'b0;
      end else begin
         rst_m_ff <= 1'b1;
         rst_s_ff <= rst_m_ff;
      end
   end

   adcss_clkdiv u_div (
      .clk_in   (clk_in),
      .rst_b_in (rst_s_ff),
      .div_in   (clkdiv_ff),
      .tick_out (tick)
   );

   adcss_sar u_sar (
      .clk_in   (clk_in),
      .rst_b_in (rst_s_ff),
      .tick_in  (tick),
      .start_in (start_ff),
      .cmp_in   (cmp_in),
      .dac_out  (dac_code),
      .busy_out (sar_busy),
      .conv_out (conv)
   );

   // decoded control and trigger events
   always_comb begin
      mode   = adcss_pkg::adcss_mode_type'(ctrl_ff[adcss_pkg::CTRL_MODE_LSB +: 3]);
      trig   = adcss_pkg::adcss_trig_type'(ctrl_ff[adcss_pkg::CTRL_TRIG_LSB +: 2]);
      imm_wr = wr_in && (addr_in == adcss_pkg::ADDR_CTRL)
               && (wdata_in[adcss_pkg::CTRL_TRIG_LSB +: 2] == 2'(adcss_pkg::ADCSS_TRIG_IMM));
      trig_evt = 1'b0;
      case (trig)
         adcss_pkg::ADCSS_TRIG_TIMER: trig_evt = timer_ovf_in;
         adcss_pkg::ADCSS_TRIG_EDGE:  trig_evt = edge_trigger_pin_in ^ pin_ff;
         default:                     trig_evt = 1'b0;
      endcase
      // lowest selected channel, wrap flag not needed here
      first_ch = 2'(find_ch(chsel_ff, 2'h0));
   end

   // register writes, flags, results, sequencer
   always_comb begin
      logic       cont;
      logic       last;
      logic [2:0] nx;
      cont = 1'b0;
      last = 1'b0;
      nx   = 3'h0;
      nxt_ctrl   = ctrl_ff;
      nxt_chsel  = chsel_ff;
      nxt_limhi  = limhi_ff;
      nxt_limlo  = limlo_ff;
      nxt_clkdiv = clkdiv_ff;
      nxt_res    = res_ff;
      nxt_done   = done_ff;
      nxt_bnd    = bnd_ff;
      nxt_early_in = early_in_ff;
      nxt_pin    = edge_trigger_pin_in;
      nxt_state  = state_ff;
      nxt_ch     = ch_ff;
      nxt_slot   = slot_ff;
      nxt_run    = run_ff;
      nxt_start  = 1'b0;
      nxt_rdata  = 8'h00;
      nxt_ana    = ana_ff;
      nxt_ana.dac_code = dac_code;
      nxt_ana.sample   = start_ff;

      // register port
      if (rd_in) begin
         case (addr_in)
            adcss_pkg::ADDR_CTRL:   nxt_rdata = ctrl_ff;
            adcss_pkg::ADDR_CHSEL:  nxt_rdata = {4'h0, chsel_ff};
            adcss_pkg::ADDR_LIMHI:  nxt_rdata = limhi_ff;
            adcss_pkg::ADDR_LIMLO:  nxt_rdata = limlo_ff;
            adcss_pkg::ADDR_STATUS: nxt_rdata = {4'h0, run_ff, sar_busy, bnd_ff, done_ff};
            4'h5, 4'h6, 4'h7, 4'h8: nxt_rdata = res_ff[2'(addr_in - adcss_pkg::ADDR_RES0)];
            adcss_pkg::ADDR_CLKDIV: nxt_rdata = clkdiv_ff;
            default:                nxt_rdata = 8'h00;
         endcase
      end
      if (wr_in) begin
         case (addr_in)
            adcss_pkg::ADDR_CTRL:   nxt_ctrl   = {1'b0, wdata_in[6:0]};
            adcss_pkg::ADDR_CHSEL:  nxt_chsel  = wdata_in[3:0];
            adcss_pkg::ADDR_LIMHI:  nxt_limhi  = wdata_in;
            adcss_pkg::ADDR_LIMLO:  nxt_limlo  = wdata_in;
            adcss_pkg::ADDR_STATUS: begin
               if (wdata_in[adcss_pkg::STAT_DONE_BIT]) nxt_done = 1'b0;
               if (wdata_in[adcss_pkg::STAT_BND_BIT])  nxt_bnd  = 1'b0;
            end
            adcss_pkg::ADDR_CLKDIV: nxt_clkdiv = wdata_in;
            default:                nxt_ctrl   = ctrl_ff;
         endcase
      end

      // software stop ends any mode
      if (wr_in && addr_in == adcss_pkg::ADDR_CTRL && wdata_in[adcss_pkg::CTRL_STOP_BIT]) begin
         nxt_run   = 1'b0;
         nxt_state = IDLE_S;
      end else begin
         case (state_ff)
            // wait for a start; triggers are only looked at here so busy ignores them
            IDLE_S, WAIT_S: begin
               if ((trig_evt || imm_wr) && chsel_ff != 4'h0) begin
                  nxt_state = CONV_S;
                  nxt_start = 1'b1;
                  nxt_run   = 1'b1;
                  if (state_ff == IDLE_S) begin
                     nxt_slot = 2'h0;
                     nxt_ch   = (mode == adcss_pkg::ADCSS_DUAL_CONT) ? first_ch : first_ch;
                  end
                  nxt_ana.chan = (state_ff == IDLE_S) ? first_ch : ch_ff;
               end
            end
            // conversions in flight ignore further trigger events
            CONV_S: begin
               if (conv.done && !start_ff) begin                               // stale result of an aborted run dropped
                  cont = (mode == adcss_pkg::ADCSS_FIX_CONT) || (mode == adcss_pkg::ADCSS_SCAN_CONT)
                         || (mode == adcss_pkg::ADCSS_DUAL_CONT);
                  if (mode == adcss_pkg::ADCSS_DUAL_CONT) begin
                     nxt_res[slot_ff] = conv.value;
                     last = (slot_ff == 2'h3);
                     nx   = find_ch(chsel_ff, 2'(ch_ff + 2'h1));
                     if (slot_ff[0])
                        nx = {1'b0, first_ch};
                     nxt_slot = 2'(slot_ff + 2'h1);
                  end else begin
                     nxt_res[ch_ff] = conv.value;
                     if (mode == adcss_pkg::ADCSS_FIX_SINGLE || mode == adcss_pkg::ADCSS_FIX_CONT) begin
                        nx   = {1'b1, ch_ff};
                        last = 1'b1;
                     end else begin
                        nx   = find_ch(chsel_ff, 2'(ch_ff + 2'h1));
                        last = nx[2] || (ch_ff == 2'h3);
                     end
                  end
                  if (mode == adcss_pkg::ADCSS_STEP || last)
                     nxt_done = 1'b1;
                  nxt_ch       = nx[1:0];
                  nxt_ana.chan = nx[1:0];
                  if (mode == adcss_pkg::ADCSS_STEP) begin
                     nxt_state = WAIT_S;
                  end else if (cont || !last) begin
                     nxt_start = 1'b1;
                  end else begin
                     nxt_state = IDLE_S;
                     nxt_run   = 1'b0;
                  end
                  // final compare only when the early check was inside
                  if (early_in_ff && outside(conv.value, limhi_ff, limlo_ff, 8'hff))
                     nxt_bnd = 1'b1;
               end else if (conv.early && !start_ff) begin
                  nxt_early_in = !outside(conv.value, limhi_ff, limlo_ff, 8'hf0);
                  if (!nxt_early_in)
                     nxt_bnd = 1'b1;
               end
            end
            default: nxt_state = IDLE_S;
         endcase
      end
   end

   // register everything
   always_ff @(posedge clk_in or negedge rst_s_ff) begin
      if (!rst_s_ff) begin
         ctrl_ff     <= adcss_pkg::CTRL_RST;
         chsel_ff    <= adcss_pkg::CHSEL_RST[3:0];
         limhi_ff    <= adcss_pkg::LIMHI_RST;
         limlo_ff    <= adcss_pkg::LIMLO_RST;
         clkdiv_ff   <= adcss_pkg::CLKDIV_RST;
         res_ff      <= '{default: 8'h00};
         done_ff     <= 1'b0;
         bnd_ff      <= 1'b0;
         early_in_ff <= 1'b0;
         rdata_ff    <= 8'h00;
         pin_ff      <= 1'b0;
         state_ff    <= IDLE_S;
         ch_ff       <= 2'h0;
         slot_ff     <= 2'h0;
         run_ff      <= 1'b0;
         start_ff    <= 1'b0;
         ana_ff      <= '0;
         done_irq_out <= 1'b0;
         bnd_irq_out  <= 1'b0;
      end else begin
         ctrl_ff     <= nxt_ctrl;
         chsel_ff    <= nxt_chsel;
         limhi_ff    <= nxt_limhi;
         limlo_ff    <= nxt_limlo;
         clkdiv_ff   <= nxt_clkdiv;
         res_ff      <= nxt_res;
         done_ff     <= nxt_done;
         bnd_ff      <= nxt_bnd;
         early_in_ff <= nxt_early_in;
         rdata_ff    <= nxt_rdata;
         pin_ff      <= nxt_pin;
         state_ff    <= nxt_state;
         ch_ff       <= nxt_ch;
         slot_ff     <= nxt_slot;
         run_ff      <= nxt_run;
         start_ff    <= nxt_start;
         ana_ff      <= nxt_ana;
         done_irq_out <= nxt_done && nxt_ctrl[adcss_pkg::CTRL_CIE_BIT];
         bnd_irq_out  <= nxt_bnd && nxt_ctrl[adcss_pkg::CTRL_BIE_BIT];
      end
   end

   assign rdata_out = rdata_ff;
   assign ana_out   = ana_ff;
endmodule // adcss_top

// file: adcss_top_asserts.sv
// checker for the a/d scan sequencer, watching only the top ports
// assumes one-cycle register strobes and a bound below
`timescale 1ns/1ns
module adcss_chk (
   input wire logic                     clk_in,
   input wire logic                     rst_b_in,
   input wire logic [3:0]               addr_in,
   input wire logic [7:0]               wdata_in,
   input wire logic                     wr_in,
   input wire logic                     rd_in,
   input wire logic [7:0]               rdata_out,
   input wire logic                     timer_ovf_in,
   input wire logic                     edge_trigger_pin_in,
   input wire logic                     cmp_in,
   input wire adcss_pkg::adcss_ana_type ana_out,
   input wire logic                     done_irq_out,
   input wire logic                     bnd_irq_out
);
   logic [3:0] sel_ff, nxt_sel;
   logic [1:0] en_ff, nxt_en;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   // shadow of channel select and interrupt enables
   always_comb begin
      nxt_sel = sel_ff;
      nxt_en = en_ff;
      if (wr_in && addr_in == adcss_pkg::ADDR_CHSEL) nxt_sel = wdata_in[3:0];
      if (wr_in && addr_in == adcss_pkg::ADDR_CTRL) nxt_en = wdata_in[6:5];
   end
   // shadow registers
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sel_ff <= adcss_pkg::CHSEL_RST[3:0];
         en_ff <= 2'h0;
      end else begin
         sel_ff <= nxt_sel;
         en_ff <= nxt_en;
      end
   end
   property p_rd_idle; !$past(rd_in) |-> rdata_out == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
   property p_unmap; rd_in && addr_in > 4'h9 |=> rdata_out == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_gap; ana_out.sample |=> !ana_out.sample [*7]; endproperty
   a_gap: assert property (p_gap) else $error("restart inside conversion");
   property p_hold; ana_out.sample |=> $stable(ana_out.chan) [*4]; endproperty
   a_hold: assert property (p_hold) else $error("channel moved in conversion");
   property p_sel; ana_out.sample |-> sel_ff[ana_out.chan]; endproperty
   a_sel: assert property (p_sel) else $error("unselected channel sampled");
   property p_bnd_off; !en_ff[1] && !$past(en_ff[1]) |-> !bnd_irq_out; endproperty
   a_bnd_off: assert property (p_bnd_off) else $error("limit irq while disabled");
   property p_done_off; !en_ff[0] && !$past(en_ff[0]) |-> !done_irq_out; endproperty
   a_done_off: assert property (p_done_off) else $error("done irq while disabled");
   property p_stop;
      wr_in && addr_in == adcss_pkg::ADDR_CTRL && wdata_in == 8'h80 |=> ##1 !ana_out.sample [*8];
   endproperty
   a_stop: assert property (p_stop) else $error("sample after stop");
   c_sample: cover property (ana_out.sample);
   c_done: cover property ($rose(done_irq_out));
   c_bnd: cover property ($rose(bnd_irq_out));
endmodule // adcss_chk
bind adcss_top adcss_chk adcss_chk_i (.clk_in, .rst_b_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
   .timer_ovf_in, .edge_trigger_pin_in, .cmp_in, .ana_out, .done_irq_out, .bnd_irq_out);

// file: adcss_top_tb.sv
// testbench for the a/d scan sequencer: register tasks and mode scenarios
// assumes the analog model answers from the live channel select
`timescale 1ns/1ns
module adcss_top_tb;
   logic                     clk_in, rst_b_in, wr_in, rd_in, timer_ovf_in, edge_trigger_pin_in;
   logic                     cmp_in, done_irq_out, bnd_irq_out;
   logic [3:0]               addr_in;
   logic [7:0]               wdata_in, rdata_out, d;
   adcss_pkg::adcss_ana_type ana_out;
   int                       n_mismatch, n_compared;
   logic [7:0]               v [4] = '{8'h35, 8'hc2, 8'h10, 8'h7e};
   logic [7:0]               hi [4] = '{8'h80, 8'h7a, 8'h7a, 8'h7a};
   logic [3:0]               sl [4] = '{4'h4, 4'h8, 4'h1, 4'h8};
   logic                     be [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
   logic                     ex [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
   adcss_top adcss_top_i (.clk_in, .rst_b_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
      .timer_ovf_in, .edge_trigger_pin_in, .cmp_in, .ana_out, .done_irq_out, .bnd_irq_out);
   adcss_ana_model adcss_ana_model_i (.clk_in, .ana_in(ana_out), .cmp_out(cmp_in));
   // core clock, 4 ns
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] dv);
      @(posedge clk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= dv;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] e, input string nm);
      @(posedge clk_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 d = rdata_out;
      chk8(nm, e, d);
   endtask
   task automatic tally_and_finish;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wait_done;
      int i;
      #1; // let a clear written at this edge reach the flag
      for (i = 0; i < 3000 && done_irq_out !== 1'b1; i++) begin
         @(posedge clk_in);
         #1;
      end
      if (i == 3000) begin
         n_mismatch++;
         $display("mismatch done_wait expected 1 seen timeout");
         tally_and_finish;
      end
   endtask
   // clear flags, let a scan finish, see nothing more run
   task automatic idle_chk(input logic [7:0] m);
      wr(adcss_pkg::ADDR_STATUS, 8'h03);
      repeat (80) @(posedge clk_in);
      @(posedge clk_in);
      rd_in <= 1'b1;
      addr_in <= adcss_pkg::ADDR_STATUS;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 chk8("status", 8'h00, rdata_out & m);
   endtask
   task automatic pulse(input logic tmr);
      @(posedge clk_in);
      if (tmr) timer_ovf_in <= 1'b1;
      else edge_trigger_pin_in <= ~edge_trigger_pin_in;
      @(posedge clk_in);
      timer_ovf_in <= 1'b0;
   endtask
   task automatic run(input logic [3:0] s, input logic [2:0] m, input logic [1:0] t, input logic b);
      wr(adcss_pkg::ADDR_CHSEL, {4'h0, s});
      wr(adcss_pkg::ADDR_STATUS, 8'h03);
      wr(adcss_pkg::ADDR_CTRL, {1'b0, b, 1'b1, t, m});
   endtask
   task automatic res_chk(input logic [3:0] s);
      for (int c = 0; c < 4; c++) if (s[c]) rdc(adcss_pkg::ADDR_RES0 + 4'(c), v[c], "result");
   endtask
   // main sequence
   initial begin
      rst_b_in = 1'b0;
      wr_in = 1'b0;
      rd_in = 1'b0;
      addr_in = 4'h0;
      wdata_in = 8'h00;
      timer_ovf_in = 1'b0;
      edge_trigger_pin_in = 1'b0;
      n_mismatch = 0;
      n_compared = 0;
      repeat (10) @(posedge clk_in);
      rst_b_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      rdc(adcss_pkg::ADDR_CTRL, adcss_pkg::CTRL_RST, "ctrl");
      rdc(adcss_pkg::ADDR_CHSEL, adcss_pkg::CHSEL_RST, "chsel");
      rdc(adcss_pkg::ADDR_LIMHI, adcss_pkg::LIMHI_RST, "limhi");
      rdc(adcss_pkg::ADDR_LIMLO, adcss_pkg::LIMLO_RST, "limlo");
      rdc(adcss_pkg::ADDR_CLKDIV, adcss_pkg::CLKDIV_RST, "clkdiv");
      wr(4'he, 8'h5a);
      rdc(4'he, 8'h00, "unmapped");
      wr(adcss_pkg::ADDR_CLKDIV, 8'h02);
      run(4'h1, adcss_pkg::ADCSS_FIX_SINGLE, adcss_pkg::ADCSS_TRIG_IMM, 1'b0);
      wait_done;
      res_chk(4'h1);
      idle_chk(8'h0f);
      run(4'hb, adcss_pkg::ADCSS_SCAN_SINGLE, adcss_pkg::ADCSS_TRIG_IMM, 1'b0);
      wait_done;
      res_chk(4'hb);
      idle_chk(8'h0f);
      run(4'hc, adcss_pkg::ADCSS_SCAN_CONT, adcss_pkg::ADCSS_TRIG_IMM, 1'b0);
      wait_done;
      wr(adcss_pkg::ADDR_STATUS, 8'h03);
      wait_done;
      wr(adcss_pkg::ADDR_CTRL, 8'h80);
      res_chk(4'hc);
      run(4'h6, adcss_pkg::ADCSS_DUAL_CONT, adcss_pkg::ADCSS_TRIG_IMM, 1'b0);
      wait_done;
      rdc(adcss_pkg::ADDR_RES0, v[1], "dual0");
      rdc(adcss_pkg::ADDR_RES0 + 4'h1, v[2], "dual1");
      rdc(adcss_pkg::ADDR_RES0 + 4'h2, v[1], "dual2");
      rdc(adcss_pkg::ADDR_RES0 + 4'h3, v[2], "dual3");
      wr(adcss_pkg::ADDR_CTRL, 8'h80);
      idle_chk(8'h0f);
      // single step on timer, a second overflow lands mid-conversion
      run(4'h3, adcss_pkg::ADCSS_STEP, adcss_pkg::ADCSS_TRIG_TIMER, 1'b0);
      pulse(1'b1);
      pulse(1'b1);
      wait_done;
      res_chk(4'h1);
      idle_chk(8'h01);
      pulse(1'b1);
      wait_done;
      res_chk(4'h2);
      // single step on pin edges, two extra edges mid-conversion
      run(4'h3, adcss_pkg::ADCSS_STEP, adcss_pkg::ADCSS_TRIG_EDGE, 1'b0);
      pulse(1'b0);
      pulse(1'b0);
      pulse(1'b0);
      wait_done;
      idle_chk(8'h01);
      pulse(1'b0);
      wait_done;
      wr(adcss_pkg::ADDR_CTRL, 8'h80);
      wr(adcss_pkg::ADDR_LIMLO, 8'h20);
      // fixed channel continuous on input 2, done after every conversion
      run(4'h4, adcss_pkg::ADCSS_FIX_CONT, adcss_pkg::ADCSS_TRIG_IMM, 1'b0);
      wait_done;
      wr(adcss_pkg::ADDR_STATUS, 8'h03);
      wait_done;
      wr(adcss_pkg::ADDR_CTRL, 8'h80);
      rdc(adcss_pkg::ADDR_RES0 + 4'h2, v[2], "fixcont");
      // limit table: early out, final out, inside, masked
      for (int k = 0; k < 4; k++) begin
         wr(adcss_pkg::ADDR_LIMHI, hi[k]);
         run(sl[k], adcss_pkg::ADCSS_FIX_SINGLE, adcss_pkg::ADCSS_TRIG_IMM, be[k]);
         wait_done;
         repeat (2) @(posedge clk_in);
         chk8("bnd_irq", {7'h0, ex[k]}, {7'h0, bnd_irq_out});
      end
      tally_and_finish;
   end
endmodule // adcss_top_tb
